// ==== l2_fib_pkg.sv ====
/*
 package for the L2 forwarding base lookup: widths, table layout,
 status bit positions, enumerations and the packed carriers.
 assumes a single clock domain and an external key hash.
*/
`default_nettype none
package l2_fib_pkg;
   localparam int MAC_W = 48;
   localparam int GID_W = 12;
   localparam int KEY_W = 60;
   localparam int HASH_W = 11;
   localparam int BKT_W = 3;
   localparam int BUCKETS = 8;
   localparam int HASH_DEPTH = 2048;
   localparam int COLL_N = 32;
   localparam int COLL_W = 5;
   localparam int ADDR_W = 15;
   localparam int TBL_DEPTH = 16416;
   localparam int PORT_W = 4;
   localparam logic [ADDR_W-1:0] COLL_BASE = 15'h4000;
   // status word {hit, stat, valid}
   localparam int ST_VALID = 0;
   localparam int ST_STAT = 1;
   localparam int ST_HIT = 2;
   localparam logic [2:0] ST_HIT_MASK = 3'h4;
   localparam logic [2:0] AGE_HIT_VALID = 3'h5;
   localparam logic [2:0] AGE_VALID_ONLY = 3'h1;
   localparam logic [2:0] ST_CLEAR = 3'h0;

   typedef enum logic [1:0] {
      CLS_NONE = 2'h0,
      CLS_LEARN = 2'h1,
      CLS_MOVE = 2'h2,
      CLS_HITUPD = 2'h3
   } sa_class_t;

   typedef enum logic [1:0] {
      SEL_KEY = 2'h0,
      SEL_DEST = 2'h1,
      SEL_STATUS = 2'h2
   } tbl_sel_t;

   typedef enum logic [1:0] {
      SC_CLEAR = 2'h0,
      SC_RUN = 2'h1,
      SC_HOLD = 2'h2
   } scan_state_t;

   typedef struct packed {
      logic valid;
      logic [MAC_W-1:0] mac;
      logic [GID_W-1:0] forwarding_group_id;
      logic [HASH_W-1:0] hash;
      logic [PORT_W-1:0] port;
   } lookup_req_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic coll;
      logic [ADDR_W-1:0] addr;
      logic [PORT_W-1:0] port;
      logic drop;
      logic flood;
   } da_result_t;

   typedef struct packed {
      logic valid;
      sa_class_t cls;
      logic hit;
      logic learned;
      logic [ADDR_W-1:0] addr;
      logic [PORT_W-1:0] storedPort;
      logic [PORT_W-1:0] srcPort;
      logic [MAC_W-1:0] mac;
      logic [GID_W-1:0] forwarding_group_id;
   } sa_result_t;

   typedef struct packed {
      logic en;
      tbl_sel_t sel;
      logic [ADDR_W-1:0] addr;
      logic [KEY_W-1:0] key;
      logic [PORT_W-1:0] port;
      logic [2:0] status;
   } tbl_wr_t;

   typedef struct packed {
      logic valid;
      logic [KEY_W-1:0] key;
      logic [PORT_W-1:0] port;
      logic [2:0] status;
   } tbl_rd_t;
endpackage
`default_nettype wire

// ==== l2_collision_cam.sv ====
/*
 collision key store: one shared copy searched by two lookups at once,
 each reporting the lowest matching entry. assumes validity is held
 in the status tables outside and writes come one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module l2_collision_cam
   import l2_fib_pkg::*;
#(
   parameter int ENTRIES = COLL_N
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic wrEn,
   input wire logic [COLL_W-1:0] wrIdx,
   input wire logic [KEY_W-1:0] wrKey,
   input wire logic [KEY_W-1:0] keyA,
   input wire logic [KEY_W-1:0] keyB,
   input wire logic [COLL_W-1:0] rdIdx,
   output logic hitA,
   output logic [COLL_W-1:0] idxA,
   output logic hitB,
   output logic [COLL_W-1:0] idxB,
   output logic [KEY_W-1:0] rdKey
);
   logic [KEY_W-1:0] keyMem [ENTRIES];
   logic [ENTRIES-1:0] matchA;
   logic [ENTRIES-1:0] matchB;

   if (ENTRIES < 1 || ENTRIES > (1 << COLL_W))
   begin : g_bad
      $error("ENTRIES does not fit the index width");
   end

   // =========================================================
   // storage and parallel compare
   for (genvar i = 0; i < ENTRIES; i++)
   begin : g_ent
      always_ff @(posedge core_clk or negedge resetn)
      begin
         if (!resetn)
            keyMem[i] <= '0;
         else if (wrEn && wrIdx == COLL_W'(i))
            keyMem[i] <= wrKey;
      end
      assign matchA[i] = keyMem[i] == keyA; // RL9
      assign matchB[i] = keyMem[i] == keyB; // RL9
   end

   assign rdKey = keyMem[rdIdx];

   // =========================================================
   // lowest matching index wins
   always_comb
   begin
      hitA = 1'b0;
      idxA = '0;
      hitB = 1'b0;
      idxB = '0;
      for (int i = ENTRIES - 1; i >= 0; i--)
      begin
         if (matchA[i])
         begin
            hitA = 1'b1; // RL4
            idxA = COLL_W'(i);
         end
         if (matchB[i])
         begin
            hitB = 1'b1;
            idxB = COLL_W'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ==== l2_fib_lookup_learn_classify.sv ====
/*
 L2 forwarding base: destination and source lookups every cycle,
 source classification, learning, hit marking and aging scan.
 assumes the 11-bit key hash arrives with each request from an
 external hash unit, and requests come from same-clock logic.
*/
// Behaviour
// RL1: key is group id and MAC, hash 11-bit
// RL2: eight buckets of 2048, read together
// RL3: bucket key equal to search key matches
// RL4: collision table returns lowest matching index
// RL5: hash hit address is bucket over hash
// RL6: collision hit address is index plus 16384
// RL7: one destination and one source lookup per cycle
// RL8: every update reaches both table copies together
// RL9: single collision table serves both lookups
// RL10: source hit needs valid status entry
// RL11: source hit compares stored port to arrival
// RL12: miss learns, mismatch moves, match hit-updates
// RL13: hardware never alters static entries
// RL14: any lookup hit on a non-static entry sets the hit flag
// RL15: status writes copy valid into shadows
// RL16: software reads and writes, pipeline only reads
// RL17: learning and aging on after reset
// RL18: per-port learn enable blocks learning
// RL19: per-port select drops or floods unknown destination
// RL20: learned entry holds port, MAC, group id
// RL21: aging removes silent non-static entries
// RL22: learned status comes from configuration input
// RL23: default learned status is valid and hit
// RL24: key hash is supplied from outside
// RL25: hash hit preferred over collision hit
`timescale 1ns/1ps
`default_nettype none
module l2_fib_lookup_learn_classify
   import l2_fib_pkg::*;
#(
   parameter int NPORTS = 12
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire lookup_req_t daReq,
   input wire lookup_req_t saReq,
   input wire tbl_wr_t swWr,
   input wire logic swRdEn,
   input wire logic [ADDR_W-1:0] swRdAddr,
   input wire logic learnOff,
   input wire logic agingOff,
   input wire logic [31:0] ageStepCycles,
   input wire logic [NPORTS-1:0] portLearnEnable,
   input wire logic [NPORTS-1:0] unknownDestDropSelect,
   input wire logic [2:0] learnInitStatus,
   output da_result_t daRes_reg,
   output sa_result_t saRes_reg,
   output tbl_rd_t swRd_reg,
   output logic ready_reg
);
   if (NPORTS < 1 || NPORTS > (1 << PORT_W))
   begin : g_bad
      $error("NPORTS does not fit the port field");
   end

   function automatic logic [BKT_W-1:0] pickHigh(input logic [7:0] v);
      pickHigh = '0;
      for (int i = 0; i < BUCKETS; i++)
         if (v[i])
            pickHigh = BKT_W'(i);
   endfunction

   function automatic logic [COLL_W-1:0] pickLow(input logic [31:0] v);
      pickLow = '0;
      for (int i = COLL_N - 1; i >= 0; i--)
         if (v[i])
            pickLow = COLL_W'(i);
   endfunction

   // =========================================================
   // tables: destination side and source-side replicas
   logic [KEY_W-1:0] keyDa [BUCKETS][HASH_DEPTH];
   logic [KEY_W-1:0] keySa [BUCKETS][HASH_DEPTH];
   logic [2:0] statusMem [TBL_DEPTH];
   logic shadowDa [TBL_DEPTH];
   logic shadowSa [TBL_DEPTH];
   logic [PORT_W-1:0] destDa [TBL_DEPTH];
   logic [PORT_W-1:0] destSa [TBL_DEPTH];

   lookup_req_t daS1_reg;
   lookup_req_t saS1_reg;
   scan_state_t scanState_reg;
   scan_state_t scanState_next;
   logic [ADDR_W-1:0] scanIdx_reg;
   logic [31:0] ageCnt_reg;
   logic cHitA;
   logic cHitB;
   logic [COLL_W-1:0] cIdxA;
   logic [COLL_W-1:0] cIdxB;
   logic [KEY_W-1:0] cRdKey;
   logic [BUCKETS-1:0] daMatch;
   logic [BUCKETS-1:0] saMatch;
   logic [BUCKETS-1:0] freeBkt;
   logic [COLL_N-1:0] freeColl;

   // =========================================================
   // key forming and bucket compare
   wire logic [KEY_W-1:0] daKey = {daS1_reg.forwarding_group_id, daS1_reg.mac}; // RL1
   wire logic [KEY_W-1:0] saKey = {saS1_reg.forwarding_group_id, saS1_reg.mac}; // RL1

   for (genvar b = 0; b < BUCKETS; b++)
   begin : g_bkt
      wire logic [ADDR_W-1:0] aDa = {1'b0, BKT_W'(b), daS1_reg.hash};
      wire logic [ADDR_W-1:0] aSa = {1'b0, BKT_W'(b), saS1_reg.hash};
      assign daMatch[b] = daS1_reg.valid && shadowDa[aDa]
         && keyDa[b][daS1_reg.hash] == daKey; // RL2 RL3
      assign saMatch[b] = saS1_reg.valid && shadowSa[aSa]
         && keySa[b][saS1_reg.hash] == saKey; // RL7 RL10
      assign freeBkt[b] = !statusMem[aSa][ST_VALID];
   end

   for (genvar c = 0; c < COLL_N; c++)
   begin : g_coll
      assign freeColl[c] = !statusMem[COLL_BASE + ADDR_W'(c)][ST_VALID];
   end

   // =========================================================
   // destination lookup result
   wire logic daHashHit = |daMatch;
   wire logic [ADDR_W-1:0] daCollAddr = COLL_BASE + ADDR_W'(cIdxA); // RL6
   wire logic daCollHit = cHitA && shadowDa[daCollAddr];
   wire logic daHit = daHashHit || daCollHit;
   wire logic [ADDR_W-1:0] daAddr = daHashHit
      ? {1'b0, pickHigh(daMatch), daS1_reg.hash} : daCollAddr; // RL5 RL25
   wire logic daDrop = daS1_reg.valid && !daHit
      && unknownDestDropSelect[daS1_reg.port]; // RL19
   wire logic daHitGo = daS1_reg.valid && daHit
      && !statusMem[daAddr][ST_STAT]; // RL14 RL13

   // =========================================================
   // source lookup and classification
   wire logic saHashHit = |saMatch;
   wire logic [ADDR_W-1:0] saCollAddr = COLL_BASE + ADDR_W'(cIdxB);
   wire logic saCollHit = cHitB && statusMem[saCollAddr][ST_VALID]; // RL10
   wire logic saHit = saHashHit || saCollHit;
   wire logic [ADDR_W-1:0] saAddr = saHashHit
      ? {1'b0, pickHigh(saMatch), saS1_reg.hash} : saCollAddr; // RL25
   wire logic [PORT_W-1:0] saStored = destSa[saAddr];
   wire logic saPortSame = saStored == saS1_reg.port; // RL11
   wire logic saStat = statusMem[saAddr][ST_STAT];
   wire sa_class_t saCls = !saS1_reg.valid ? CLS_NONE
      : !saHit ? CLS_LEARN : saPortSame ? CLS_HITUPD : CLS_MOVE; // RL12
   wire logic learnAllow = !learnOff && !swWr.en
      && portLearnEnable[saS1_reg.port]; // RL17 RL18
   wire logic slotHash = |freeBkt;
   wire logic [COLL_W-1:0] freeBktIdx = pickLow({24'h0, freeBkt});
   wire logic [ADDR_W-1:0] slot = slotHash
      ? {1'b0, freeBktIdx[BKT_W-1:0], saS1_reg.hash}
      : COLL_BASE + ADDR_W'(pickLow(freeColl));
   wire logic learnGo = saCls == CLS_LEARN && learnAllow
      && (slotHash || |freeColl);
   wire logic moveGo = saCls == CLS_MOVE && learnAllow && !saStat; // RL13
   wire logic saHitGo = saS1_reg.valid && saHit && !saStat; // RL14

   // =========================================================
   // shared collision store
   wire logic swKey = swWr.en && swWr.sel == SEL_KEY;
   wire logic swColl = swWr.addr >= COLL_BASE;
   wire logic [BKT_W-1:0] swBkt = swWr.addr[ADDR_W-2 -: BKT_W];
   wire logic [HASH_W-1:0] swIdx = swWr.addr[HASH_W-1:0];
   wire logic collWr = (swKey && swColl) || (learnGo && !slotHash);
   wire logic [COLL_W-1:0] collWrIdx = swWr.en
      ? swWr.addr[COLL_W-1:0] : slot[COLL_W-1:0];
   wire logic [KEY_W-1:0] collWrKey = swWr.en ? swWr.key : saKey;

   l2_collision_cam #(.ENTRIES(COLL_N)) uColl
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .wrEn(collWr),
      .wrIdx(collWrIdx),
      .wrKey(collWrKey),
      .keyA(daKey),
      .keyB(saKey),
      .rdIdx(swRdAddr[COLL_W-1:0]),
      .hitA(cHitA),
      .idxA(cIdxA),
      .hitB(cHitB),
      .idxB(cIdxB),
      .rdKey(cRdKey)
   );

   // =========================================================
   // clear after reset, then aging scan
   wire logic ageStep = ageCnt_reg == 32'h0;
   wire logic [2:0] scanStatus = statusMem[scanIdx_reg];
   wire logic scanLast = scanIdx_reg == ADDR_W'(TBL_DEPTH - 1);
   wire logic clearing = scanState_reg == SC_CLEAR;
   wire logic scanRun = scanState_reg == SC_RUN && !agingOff;
   wire logic ageGo = scanRun && ageStep
      && (scanStatus == AGE_HIT_VALID || scanStatus == AGE_VALID_ONLY)
      && !(daHitGo && daAddr == scanIdx_reg)
      && !(saHitGo && saAddr == scanIdx_reg); // RL21 RL13
   wire logic [2:0] ageNew = scanStatus == AGE_HIT_VALID
      ? AGE_VALID_ONLY : ST_CLEAR;
   wire logic scanAdv = clearing || (scanRun && ageStep);

   always_comb
   begin
      scanState_next = scanState_reg;
      case (scanState_reg)
         SC_CLEAR: if (scanLast) scanState_next = SC_RUN; // RL17
         SC_RUN: if (agingOff) scanState_next = SC_HOLD;
         SC_HOLD: if (!agingOff) scanState_next = SC_RUN;
         default: scanState_next = SC_HOLD;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scanState_reg <= SC_CLEAR;
         scanIdx_reg <= '0;
         ageCnt_reg <= '0;
      end
      else
      begin
         scanState_reg <= scanState_next;
         if (scanState_next == SC_HOLD)
            scanIdx_reg <= '0;
         else if (scanAdv)
            scanIdx_reg <= scanLast ? '0 : scanIdx_reg + 1'b1;
         if (!scanRun || ageCnt_reg >= ageStepCycles)
            ageCnt_reg <= '0;
         else
            ageCnt_reg <= ageCnt_reg + 32'h1;
      end
   end

   // =========================================================
   // table writes, later statements take priority
   always_ff @(posedge core_clk)
   begin
      if (clearing)
      begin
         statusMem[scanIdx_reg] <= ST_CLEAR;
         shadowDa[scanIdx_reg] <= 1'b0;
         shadowSa[scanIdx_reg] <= 1'b0;
      end
      if (ageGo)
      begin
         statusMem[scanIdx_reg] <= ageNew; // RL21
         shadowDa[scanIdx_reg] <= ageNew[ST_VALID]; // RL15
         shadowSa[scanIdx_reg] <= ageNew[ST_VALID]; // RL8
      end
      if (daHitGo)
         statusMem[daAddr] <= statusMem[daAddr] | ST_HIT_MASK; // RL14
      if (saHitGo)
         statusMem[saAddr] <= statusMem[saAddr] | ST_HIT_MASK; // RL14
      if (learnGo)
      begin
         if (slotHash)
         begin
            keyDa[freeBktIdx[BKT_W-1:0]][saS1_reg.hash] <= saKey; // RL20
            keySa[freeBktIdx[BKT_W-1:0]][saS1_reg.hash] <= saKey; // RL8
         end
         destDa[slot] <= saS1_reg.port; // RL20
         destSa[slot] <= saS1_reg.port;
         statusMem[slot] <= learnInitStatus; // RL22 RL23
         shadowDa[slot] <= learnInitStatus[ST_VALID]; // RL15
         shadowSa[slot] <= learnInitStatus[ST_VALID];
      end
      if (moveGo)
      begin
         destDa[saAddr] <= saS1_reg.port;
         destSa[saAddr] <= saS1_reg.port; // RL8
      end
      if (swKey && !swColl)
      begin
         keyDa[swBkt][swIdx] <= swWr.key; // RL16
         keySa[swBkt][swIdx] <= swWr.key; // RL8
      end
      if (swWr.en && swWr.sel == SEL_DEST)
      begin
         destDa[swWr.addr] <= swWr.port;
         destSa[swWr.addr] <= swWr.port; // RL8
      end
      if (swWr.en && swWr.sel == SEL_STATUS)
      begin
         statusMem[swWr.addr] <= swWr.status; // RL16
         shadowDa[swWr.addr] <= swWr.status[ST_VALID];
         shadowSa[swWr.addr] <= swWr.status[ST_VALID]; // RL8
      end
   end

   // =========================================================
   // pipeline and answer registers
   wire logic [BKT_W-1:0] rdBkt = swRdAddr[ADDR_W-2 -: BKT_W];
   wire tbl_rd_t swRdNext = '{valid: swRdEn,
      key: swRdAddr >= COLL_BASE ? cRdKey
         : keyDa[rdBkt][swRdAddr[HASH_W-1:0]],
      port: destDa[swRdAddr], status: statusMem[swRdAddr]};
   wire da_result_t daResNext = '{valid: daS1_reg.valid,
      hit: daHit, coll: !daHashHit && daCollHit, addr: daAddr,
      port: destDa[daAddr], drop: daDrop,
      flood: daS1_reg.valid && !daHit && !daDrop};
   wire sa_result_t saResNext = '{valid: saS1_reg.valid, cls: saCls,
      hit: saHit, learned: learnGo, addr: learnGo ? slot : saAddr,
      storedPort: saStored, srcPort: saS1_reg.port,
      mac: saS1_reg.mac, forwarding_group_id: saS1_reg.forwarding_group_id};

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         daS1_reg <= '0;
         saS1_reg <= '0;
         daRes_reg <= '0;
         saRes_reg <= '0;
         swRd_reg <= '0;
         ready_reg <= 1'b0;
      end
      else
      begin
         daS1_reg <= daReq; // RL24
         saS1_reg <= saReq; // RL7
         daRes_reg <= daResNext;
         saRes_reg <= saResNext;
         swRd_reg <= swRdNext;
         ready_reg <= scanState_next != SC_CLEAR;
      end
   end

   // =========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_da_answer_time: assert property ( // RL7
      daReq.valid |-> ##2 daRes_reg.valid)
      else $error("destination answer missing");
   a_sa_answer_time: assert property ( // RL7
      saReq.valid |-> ##2 saRes_reg.valid && saRes_reg.cls != CLS_NONE)
      else $error("source answer missing");
   a_hash_index: assert property ( // RL5
      daRes_reg.valid && daRes_reg.hit && !daRes_reg.coll |->
      daRes_reg.addr[HASH_W-1:0] == $past(daReq.hash, 2)
      && !daRes_reg.addr[ADDR_W-1])
      else $error("hash hit address wrong");
   a_coll_offset: assert property ( // RL6
      daRes_reg.valid && daRes_reg.coll |->
      daRes_reg.addr >= COLL_BASE && daRes_reg.addr < TBL_DEPTH)
      else $error("collision address out of range");
   a_sa_classify: assert property ( // RL12
      saRes_reg.valid |-> saRes_reg.cls == (!saRes_reg.hit ? CLS_LEARN
      : saRes_reg.storedPort == saRes_reg.srcPort ? CLS_HITUPD : CLS_MOVE))
      else $error("source class wrong");
   a_miss_action: assert property ( // RL19
      daRes_reg.valid |-> (daRes_reg.hit ? !daRes_reg.drop
      && !daRes_reg.flood : daRes_reg.drop != daRes_reg.flood))
      else $error("unknown destination action wrong");
   a_static_kept: assert property ( // RL13
      scanRun && scanStatus[ST_STAT] && !swWr.en |=>
      statusMem[$past(scanIdx_reg)] == $past(scanStatus))
      else $error("static entry altered");
   a_learn_gate: assert property ( // RL18
      saRes_reg.learned |-> $past(portLearnEnable[saS1_reg.port])
      && !$past(learnOff))
      else $error("learning not allowed");
   a_learn_status: assert property ( // RL22
      learnGo |=> statusMem[$past(slot)] == $past(learnInitStatus))
      else $error("learned status wrong");
   a_shadow_copy: assert property ( // RL15
      ageGo && !swWr.en |=> shadowDa[$past(scanIdx_reg)]
      == $past(ageNew[ST_VALID]) && shadowSa[$past(scanIdx_reg)]
      == $past(ageNew[ST_VALID]))
      else $error("shadow not updated");
   a_hit_mark: assert property ( // RL14
      daHitGo && !swWr.en |=> statusMem[$past(daAddr)][ST_HIT])
      else $error("hit flag not set");

   c_learn: cover property (saRes_reg.learned);
   c_move: cover property (saRes_reg.cls == CLS_MOVE);
   c_coll_hit: cover property (daRes_reg.coll);
   c_age_clear: cover property (ageGo && ageNew == ST_CLEAR);
endmodule
`default_nettype wire

// ==== ingress_pipe_model.sv ====
/*
 ingress pipeline model: issues destination and source lookups.
 assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ingress_pipe_model
   import l2_fib_pkg::*;
(
   input wire logic core_clk,
   output lookup_req_t daReq,
   output lookup_req_t saReq
);
   // ==========================
   // request drive
   initial
   begin
      daReq = '0;
      saReq = '0;
   end

   // one destination and one source request per cycle
   task automatic look(input logic dv, input logic [KEY_W-1:0] dk,
      input logic [HASH_W-1:0] dh, input logic sv,
      input logic [KEY_W-1:0] sk, input logic [HASH_W-1:0] sh,
      input logic [PORT_W-1:0] p);
      daReq = {dv, dk[MAC_W-1:0], dk[KEY_W-1:MAC_W], dh, p};
      saReq = {sv, sk[MAC_W-1:0], sk[KEY_W-1:MAC_W], sh, p};
      @(posedge core_clk);
      #1;
   endtask

   // released lines carry an inverted pattern; valid held low
   task automatic rest();
      daReq = {1'h0, ~daReq[$bits(lookup_req_t)-2:0]};
      saReq = {1'h0, ~saReq[$bits(lookup_req_t)-2:0]};
   endtask
endmodule
`default_nettype wire

// ==== l2_fib_lookup_learn_classify_bench.sv ====
/*
 self-checking bench for the L2 forwarding base lookup.
 assumes the pipeline model drives requests, aging enabled last.
*/
`timescale 1ns/1ps
`default_nettype none
module l2_fib_lookup_learn_classify_bench;
   import l2_fib_pkg::*;
   logic core_clk;
   logic resetn;
   lookup_req_t daReq;
   lookup_req_t saReq;
   tbl_wr_t swWr;
   logic swRdEn;
   logic [ADDR_W-1:0] swRdAddr;
   logic learnOff;
   logic agingOff;
   logic [2:0] learnInitStatus;
   logic [11:0] portLearnEnable;
   logic [11:0] unknownDestDropSelect;
   da_result_t daRes_reg;
   sa_result_t saRes_reg;
   tbl_rd_t swRd_reg;
   logic ready_reg;
   int nErrors = 0;
   int checksDone = 0;
   int seed = 28702;
   logic [35:0] daQ[$];
   logic [35:0] saQ[$];
   logic [35:0] rdQ[$];
   logic [KEY_W-1:0] k1, k2, k3;
   logic [HASH_W-1:0] h, h2, h3;
   logic [ADDR_W-1:0] collAddr;

   l2_fib_lookup_learn_classify DUT (.core_clk, .resetn, .daReq, .saReq,
      .swWr, .swRdEn, .swRdAddr, .learnOff, .agingOff,
      .ageStepCycles(32'h0), .portLearnEnable, .unknownDestDropSelect,
      .learnInitStatus, .daRes_reg, .saRes_reg, .swRd_reg,
      .ready_reg);
   ingress_pipe_model PM (.core_clk, .daReq, .saReq);

   // ==========================
   // clock and watchdog
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial
   begin
      #300000;
      nErrors++;
      endSim();
   end

   // ==========================
   // checking
   task automatic endSim();
      if (daQ.size() + saQ.size() + rdQ.size() > 0)
      begin
         nErrors++;
         $display("Error at %0t got %h expected %h", $time,
            daQ.size() + saQ.size() + rdQ.size(), 0);
      end
      $display("checks %0d mismatches %0d", checksDone, nErrors);
      if (nErrors == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [17:0] got, input logic [35:0] me);
      checksDone++;
      if ((got & me[35:18]) !== me[17:0])
      begin
         nErrors++;
         $display("Error at %0t got %h expected %h", $time,
            got & me[35:18], me[17:0]);
      end
   endtask
   task automatic chkDa(input logic [35:0] me);
      chk({daRes_reg.hit, daRes_reg.coll, daRes_reg.addr, daRes_reg.drop},
         me);
   endtask
   task automatic chkSa(input logic [35:0] me);
      chk({saRes_reg.cls, saRes_reg.learned, saRes_reg.addr}, me);
   endtask
   task automatic chkRd(input logic [35:0] me);
      chk({10'h0, swRd_reg.valid, swRd_reg.status, swRd_reg.port}, me);
   endtask
   function automatic logic [35:0] daExp(logic hit, logic coll,
      logic [ADDR_W-1:0] a, logic drop);
      return hit ? {18'h3FFFE, hit, coll, a, 1'h0}
                 : {18'h30001, 17'h0, drop};
   endfunction
   function automatic logic [35:0] saExp(sa_class_t c, logic l,
      logic [ADDR_W-1:0] a);
      return (c == CLS_LEARN && !l) ? {18'h38000, c, 16'h0}
                                    : {18'h3FFFF, c, l, a};
   endfunction
   // results taken off the queues as they appear
   always @(negedge core_clk)
   begin
      if (daRes_reg.valid === 1'b1)
         chkDa(daQ.size() > 0 ? daQ.pop_front() : '1);
      if (saRes_reg.valid === 1'b1)
         chkSa(saQ.size() > 0 ? saQ.pop_front() : '1);
      if (swRd_reg.valid === 1'b1)
         chkRd(rdQ.size() > 0 ? rdQ.pop_front() : '1);
   end

   // ==========================
   // drivers
   task automatic lk(input logic dv, input logic [KEY_W-1:0] dk,
      input logic [HASH_W-1:0] dh, input logic sv,
      input logic [KEY_W-1:0] sk, input logic [HASH_W-1:0] sh,
      input logic [PORT_W-1:0] p, input logic [35:0] dE,
      input logic [35:0] sE);
      if (dv)
         daQ.push_back(dE);
      if (sv)
         saQ.push_back(sE);
      PM.look(dv, dk, dh, sv, sk, sh, p);
   endtask
   task automatic sw(input tbl_sel_t s, input logic [ADDR_W-1:0] a,
      input logic [KEY_W-1:0] k, input logic [PORT_W-1:0] p,
      input logic [2:0] st);
      PM.rest();
      swWr = {1'h1, s, a, k, p, st};
      @(posedge core_clk);
      #1;
   endtask
   task automatic rest(input int n);
      PM.rest();
      swWr.en = 1'b0;
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // ==========================
   // scenarios
   initial
   begin
      resetn = 1'b0;
      swWr = '0;
      swRdEn = 1'b0;
      swRdAddr = '0;
      learnOff = 1'b0;
      agingOff = 1'b1;
      learnInitStatus = 3'h5;
      portLearnEnable = 12'hFFF;
      unknownDestDropSelect = 12'h020;
      k1 = KEY_W'({$random(seed), $random(seed)});
      k2 = KEY_W'({$random(seed), $random(seed)});
      k3 = KEY_W'({$random(seed), $random(seed)});
      h = HASH_W'($random(seed));
      h2 = h ^ 11'h001;
      h3 = h ^ 11'h002;
      collAddr = COLL_BASE + 15'h0003;
      repeat (2) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      for (int i = 0; i < 17000 && ready_reg !== 1'b1; i++)
         @(posedge core_clk);
      #1;
      chk({17'h0, ready_reg}, {18'h3FFFF, 18'h1});
      lk(0, '0, '0, 1, k1, h, 4'h2, '0, saExp(CLS_LEARN, 1, {4'h0, h}));
      rest(4);
      $display("learn test done");
      lk(1, k1, h, 1, k1, h, 4'h2, daExp(1, 0, {4'h0, h}, 0),
         saExp(CLS_HITUPD, 0, {4'h0, h}));
      lk(0, '0, '0, 1, k1, h, 4'h3, '0, saExp(CLS_MOVE, 0, {4'h0, h}));
      lk(1, k2, h2, 0, '0, '0, 4'h5, daExp(0, 0, '0, 1), '0);
      lk(1, k2, h2, 0, '0, '0, 4'h6, daExp(0, 0, '0, 0), '0);
      rest(4);
      $display("hit move and unknown test done");
      sw(SEL_KEY, collAddr, k2, 4'h0, 3'h0);
      sw(SEL_DEST, collAddr, '0, 4'h4, 3'h0);
      sw(SEL_STATUS, collAddr, '0, 4'h0, 3'h1);
      rest(2);
      lk(1, k2, h2, 1, k2, h2, 4'h4, daExp(1, 1, collAddr, 0),
         saExp(CLS_HITUPD, 0, collAddr));
      sw(SEL_KEY, {1'h0, 3'h5, h2}, k2, 4'h0, 3'h0);
      sw(SEL_STATUS, {1'h0, 3'h5, h2}, '0, 4'h0, 3'h1);
      rest(2);
      lk(1, k2, h2, 0, '0, '0, 4'h4, daExp(1, 0, {1'h0, 3'h5, h2}, 0), '0);
      rest(4);
      $display("collision test done");
      portLearnEnable = 12'hF7F;
      lk(0, '0, '0, 1, k3, h3, 4'h7, '0, saExp(CLS_LEARN, 0, '0));
      learnOff = 1'b1;
      lk(0, '0, '0, 1, k3, h3, 4'h2, '0, saExp(CLS_LEARN, 0, '0));
      rest(4);
      learnOff = 1'b0;
      lk(1, k3, h3, 0, '0, '0, 4'h2, daExp(0, 0, '0, 0), '0);
      rest(4);
      learnInitStatus = 3'h3;
      lk(0, '0, '0, 1, k3, h3, 4'h2, '0,
         saExp(CLS_LEARN, 1, {4'h0, h3}));
      rest(4);
      $display("learn disable test done");
      rdQ.push_back({18'h3FFFF, 10'h0, 1'h1, 3'h5, 4'h3});
      swRdEn = 1'b1;
      swRdAddr = {4'h0, h};
      @(posedge core_clk);
      #1;
      swRdEn = 1'b0;
      rest(4);
      $display("read test done");
      agingOff = 1'b0;
      rest(33000);
      lk(1, k1, h, 1, k3, h3, 4'h2, daExp(0, 0, '0, 0),
         saExp(CLS_HITUPD, 0, {4'h0, h3}));
      lk(1, k3, h3, 0, '0, '0, 4'h2, daExp(1, 0, {4'h0, h3}, 0), '0);
      rest(4);
      $display("aging test done");
      endSim();
   end
endmodule
`default_nettype wire
